// file: core/fwsr_pkg.sv
// package for the flash write status host controller
package fwsr_pkg;
  // register byte offsets
  localparam logic [3:0] FWSR_REG_CMD = 4'h0;
  localparam logic [3:0] FWSR_REG_ADDR = 4'h4;
  localparam logic [3:0] FWSR_REG_DATA = 4'h8;
  localparam logic [3:0] FWSR_REG_STAT = 4'hC;
  // command field values
  localparam logic [1:0] FWSR_CMD_WRITE = 2'h1;
  localparam logic [1:0] FWSR_CMD_READ = 2'h2;
  localparam logic [1:0] FWSR_CMD_POLL = 2'h3;
  // status bit positions
  localparam int FWSR_ST_BUSY = 0;
  localparam int FWSR_ST_DONE = 1;
  localparam int FWSR_ST_FAIL = 2;
  localparam int FWSR_ST_RDY = 3;
  localparam int FWSR_ST_WIN = 4;
  localparam int FWSR_ST_SUSP = 5;
  // flash data bit positions
  localparam int FWSR_BIT_POLL = 7;
  localparam int FWSR_BIT_TOG1 = 6;
  localparam int FWSR_BIT_TMO = 5;
  localparam int FWSR_BIT_WIN = 3;
  localparam int FWSR_BIT_TOG2 = 2;
  localparam logic [7:0] FWSR_RESET_CMD = 8'hF0;
  // bus cycle timing
  localparam int FWSR_CLK_MHZ = 40;
  localparam int FWSR_STROBE_NS = 100;
  localparam logic [3:0] FWSR_STROBE_CYC = 4'((FWSR_STROBE_NS * FWSR_CLK_MHZ + 999) / 1000);
  localparam logic [19:0] FWSR_ADDR_RST = 20'h00000;
  localparam logic [7:0] FWSR_DATA_RST = 8'h00;
  typedef enum logic [3:0] {
    FWSR_IDLE = 4'h0,
    FWSR_WR_ACT = 4'h1,
    FWSR_WR_REL = 4'h2,
    FWSR_RD_ACT = 4'h3,
    FWSR_RD_REL = 4'h4,
    FWSR_PL_EVAL = 4'h5,
    FWSR_RST_ACT = 4'h6,
    FWSR_RST_REL = 4'h7
  } fwsr_state_type;
endpackage

// file: core/fwsr_host.sv
// host controller driving flash bus cycles and toggle polling
// Operation
// - host combines both toggle bits for sector and mode status
// - host reads twice; unchanged toggle means operation complete
// - toggling with timeout high: recheck; still toggling means failure
// - host resuming polling restarts from its first double read; here host reads once more and compares with the previous read
// - after timeout failure host writes reset command
// - host may skip window flag only if commands under 50 us apart; this host never checks it itself
// - host checks window flag before and after each added sector; here the flag is only reported as status bit 4
// - host gives valid address when reading polling or second toggle bit
// - reset command is one write of F0 at any address
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fwsr_host (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [19:0] flash_addr_out,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  input wire logic busy_open_drain_in
);
  import fwsr_pkg::*;

  fwsr_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic [7:0] prev_r, prev_nxt;
  logic [1:0] nrd_r, nrd_nxt;
  logic tmo_seen_r, tmo_seen_nxt;
  logic done_r, done_nxt, fail_r, fail_nxt, susp_r, susp_nxt;
  logic busy_s1_r, busy_s2_r;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, dqoe_r, dqoe_nxt;
  logic [7:0] dqo_r, dqo_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [3:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] cmd;
  logic start_wr, start_rd, start_pl;
  // bus capture: accept aw and w in either order, answer after both
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    if (s_axi_awvalid_in && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata_in;
    end
    if (aw_r && w_r && !bv_r) begin
      bv_nxt = 1'b1;
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
    end
    if (bv_r && s_axi_bready_in) begin
      bv_nxt = 1'b0;
    end
  end
  assign cmd = wd_r[1:0];
  assign start_wr = aw_r && w_r && !bv_r && awa_r == FWSR_REG_CMD && cmd == FWSR_CMD_WRITE;
  assign start_rd = aw_r && w_r && !bv_r && awa_r == FWSR_REG_CMD && cmd == FWSR_CMD_READ;
  assign start_pl = aw_r && w_r && !bv_r && awa_r == FWSR_REG_CMD && cmd == FWSR_CMD_POLL;
  // read channel: data answers the cycle after arready, never together with it
  always_comb begin
    arr_nxt = 1'b0;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    if (arr_r) rv_nxt = 1'b1;
    if (s_axi_arvalid_in && !rv_r && !arr_r) begin
      arr_nxt = 1'b1;
      case (s_axi_araddr_in)
        FWSR_REG_ADDR: rd_nxt = {12'h000, addr_r};
        FWSR_REG_DATA: rd_nxt = {16'h0000, rdat_r, wdat_r};
        FWSR_REG_STAT: rd_nxt = {26'h0000000, susp_r, rdat_r[FWSR_BIT_WIN], busy_s2_r,
                                 fail_r, done_r, st_r != FWSR_IDLE};
        default: rd_nxt = 32'h00000000;
      endcase
    end
    if (rv_r && s_axi_rready_in) begin
      rv_nxt = 1'b0;
    end
  end
  // flash cycle sequencer and toggle poll
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    prev_nxt = prev_r;
    nrd_nxt = nrd_r;
    tmo_seen_nxt = tmo_seen_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    susp_nxt = susp_r;
    ce_n_nxt = 1'b1;
    oe_n_nxt = 1'b1;
    we_n_nxt = 1'b1;
    dqoe_nxt = 1'b1;
    dqo_nxt = dqo_r;
    if (aw_r && w_r && !bv_r && st_r == FWSR_IDLE) begin
      if (awa_r == FWSR_REG_ADDR) addr_nxt = wd_r[19:0];
      if (awa_r == FWSR_REG_DATA) wdat_nxt = wd_r[7:0];
    end
    case (st_r)
      FWSR_IDLE: begin
        cnt_nxt = FWSR_STROBE_CYC;
        if (start_wr) begin
          st_nxt = FWSR_WR_ACT;
          dqo_nxt = wdat_r;
        end else if (start_rd) begin
          st_nxt = FWSR_RD_ACT;
          nrd_nxt = 2'h0;
        end else if (start_pl) begin
          st_nxt = FWSR_RD_ACT;
          nrd_nxt = 2'h2;
          tmo_seen_nxt = 1'b0;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
        end
      end
      FWSR_WR_ACT, FWSR_RST_ACT: begin
        ce_n_nxt = 1'b0;
        we_n_nxt = 1'b0;
        dqoe_nxt = 1'b0;
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          we_n_nxt = 1'b1;
          st_nxt = (st_r == FWSR_WR_ACT) ? FWSR_WR_REL : FWSR_RST_REL;
          cnt_nxt = FWSR_STROBE_CYC;
        end
      end
      FWSR_WR_REL, FWSR_RST_REL: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) st_nxt = FWSR_IDLE;
      end
      FWSR_RD_ACT: begin
        ce_n_nxt = 1'b0;
        oe_n_nxt = 1'b0;
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          oe_n_nxt = 1'b1;
          rdat_nxt = dq_s2_r;
          prev_nxt = rdat_r;
          st_nxt = FWSR_RD_REL;
          cnt_nxt = FWSR_STROBE_CYC;
        end
      end
      FWSR_RD_REL: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          cnt_nxt = FWSR_STROBE_CYC;
          if (nrd_r == 2'h2) begin
            st_nxt = FWSR_RD_ACT;
            nrd_nxt = 2'h1;
          end else if (nrd_r == 2'h1) begin
            st_nxt = FWSR_PL_EVAL;
          end else begin
            st_nxt = FWSR_IDLE;
          end
        end
      end
      FWSR_PL_EVAL: begin
        cnt_nxt = FWSR_STROBE_CYC;
        if (prev_r[FWSR_BIT_TOG1] == rdat_r[FWSR_BIT_TOG1]) begin
          done_nxt = 1'b1;
          susp_nxt = busy_s2_r && prev_r[FWSR_BIT_TOG2] != rdat_r[FWSR_BIT_TOG2];
          st_nxt = FWSR_IDLE;
        end else if (tmo_seen_r) begin
          fail_nxt = 1'b1;
          st_nxt = FWSR_RST_ACT;
          dqo_nxt = FWSR_RESET_CMD;
        end else begin
          tmo_seen_nxt = rdat_r[FWSR_BIT_TMO];
          st_nxt = FWSR_RD_ACT;
          nrd_nxt = 2'h1;
        end
      end
      default: st_nxt = FWSR_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= FWSR_IDLE;
      cnt_r <= 4'h0;
      addr_r <= FWSR_ADDR_RST;
      wdat_r <= FWSR_DATA_RST;
      rdat_r <= FWSR_DATA_RST;
      prev_r <= FWSR_DATA_RST;
      nrd_r <= 2'h0;
      tmo_seen_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      susp_r <= 1'b0;
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      dqoe_r <= 1'b1;
      dqo_r <= 8'h00;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      arr_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= 4'h0;
      wd_r <= 32'h00000000;
      rd_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      prev_r <= prev_nxt;
      nrd_r <= nrd_nxt;
      tmo_seen_r <= tmo_seen_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      susp_r <= susp_nxt;
      busy_s1_r <= busy_open_drain_in;
      busy_s2_r <= busy_s1_r;
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      dqoe_r <= dqoe_nxt;
      dqo_r <= dqo_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      arr_r <= arr_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign s_axi_awready_out = aw_r;
  assign s_axi_wready_out = w_r;
  assign s_axi_bvalid_out = bv_r;
  assign s_axi_bresp_out = 2'h0;
  assign s_axi_arready_out = arr_r;
  assign s_axi_rvalid_out = rv_r;
  assign s_axi_rdata_out = rd_r;
  assign s_axi_rresp_out = 2'h0;
  assign flash_addr_out = addr_r;
  assign flash_dq_out = dqo_r;
  assign flash_dq_oe_out = dqoe_r;
  assign flash_ce_n_out = ce_n_r;
  assign flash_oe_n_out = oe_n_r;
  assign flash_we_n_out = we_n_r;
endmodule

// file: tb/fwsr_host_assertions.sv
// concurrent checks on the flash status host controller ports
`timescale 1ns/1ps
module fwsr_host_chk (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_awready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  chk_strobe_excl: assert property (!flash_we_n_out |-> flash_oe_n_out)
    else $error("read and write strobes low together");
  chk_write_drive: assert property (!flash_we_n_out |-> !flash_dq_oe_out && !flash_ce_n_out)
    else $error("write strobe without driven data");
  chk_read_release: assert property (!flash_oe_n_out |-> flash_dq_oe_out && !flash_ce_n_out)
    else $error("read strobe while data driven");
  chk_we_width: assert property ($fell(flash_we_n_out) |-> !flash_we_n_out[*3])
    else $error("write strobe too short");
  chk_oe_width: assert property ($fell(flash_oe_n_out) |-> !flash_oe_n_out[*3])
    else $error("read strobe too short");
  chk_wdata_stable: assert property (!flash_we_n_out && $past(!flash_we_n_out)
    |-> $stable(flash_dq_out))
    else $error("write data moved under strobe");
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped or changed");
  chk_b_okay: assert property (s_axi_bvalid_out |-> s_axi_bresp_out == 2'h0)
    else $error("write response not okay");
endmodule
bind fwsr_host fwsr_host_chk i_chk (.*);

// file: tb/fwsr_flash_model.sv
// behavioural flash device answering host strobes with write status bits
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [7:0] dq_in,
  input wire logic [3:0] len_in,
  input wire logic stuck_in,
  input wire logic [1:0] mode_in,
  output logic [7:0] dq_out,
  output logic busy_pull_out
);
  // mode_in: 0 program, 1 sector erase, 2 erase suspended
  logic run = 1'h0;
  logic tog = 1'h0;
  logic tog2 = 1'h0;
  logic tmo = 1'h0;
  logic win = 1'h0;
  logic we_low = 1'h0;
  logic oe_low = 1'h0;
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] drv;
  int left = 0;
  // only a strobe seen low counts, so strobes settling in reset issue nothing
  always @(negedge we_n_in) we_low = 1'h1;
  always @(negedge oe_n_in) oe_low = 1'h1;
  // command ends at write strobe rising edge
  always @(posedge we_n_in) begin
    if (we_low) begin
      we_low = 1'h0;
      if (dq_in == FWSR_RESET_CMD) begin
        run = 1'h0;
        tmo = 1'h0;
      end else if (!(run && mode_in == 2'h1 && win)) begin
        run = 1'h1;
        left = len_in;
        pd = dq_in;
        win = 1'h0;
      end
    end
  end
  // each finished read while running advances the algorithm; in erase suspend only the second toggle bit moves
  always @(posedge oe_n_in) begin
    if (oe_low && run) begin
      win = 1'h1;
      if (mode_in != 2'h0) tog2 = ~tog2;
      if (mode_in != 2'h2) begin
        tog = ~tog;
        if (left > 0) left = left - 1;
        else if (stuck_in) tmo = 1'h1;
        else run = 1'h0;
      end
    end
    oe_low = 1'h0;
  end
  always_comb begin
    drv = pd;
    if (run) begin
      case (mode_in)
        2'h1: drv = {1'h0, tog, tmo, 1'h0, win, tog2, 2'h0};
        2'h2: drv = {1'h1, tog, 3'h0, tog2, 2'h0};
        default: drv = {~pd[7], tog, tmo, 5'h00};
      endcase
    end
  end
  always @* if (!oe_n_in) last = drv;
  assign dq_out = oe_n_in ? ~last : drv;
  assign busy_pull_out = run && mode_in != 2'h2;
endmodule

// file: tb/testbench.sv
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
module testbench;
  import fwsr_pkg::*;
  logic clk_sys_in = 1'h0, rstn_in = 1'h0;
  logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hF;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, r, a;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, stuck = 1'h0, pull;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [19:0] flash_addr_out;
  logic [7:0] flash_dq_out, mdq, d;
  logic [7:0] q[$];
  logic [3:0] len = 4'h1;
  logic [1:0] mode = 2'h0;
  int n_errors = 0, num_checks = 0, k, j;
  wire [7:0] flash_dq_in = flash_dq_oe_out ? mdq : flash_dq_out;
  wire busy_open_drain_in = pull ? 1'h0 : 1'h1;
  always #12.5 clk_sys_in = ~clk_sys_in;
  fwsr_host i_dut (.*);
  fwsr_flash_model i_flash (.we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out),
    .dq_in(flash_dq_in), .len_in(len), .stuck_in(stuck), .mode_in(mode), .dq_out(mdq),
    .busy_pull_out(pull));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [3:0] ad, input logic [31:0] dat);
    s_axi_awaddr_in <= ad;
    s_axi_wdata_in <= dat;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
    end while (s_axi_bvalid_out !== 1'h1);
    s_axi_bready_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic axr(input logic [3:0] ad);
    s_axi_araddr_in <= ad;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
    end while (s_axi_rvalid_out !== 1'h1);
    r = s_axi_rdata_out;
    s_axi_rready_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic idle;
    do axr(FWSR_REG_STAT); while (r[FWSR_ST_BUSY] !== 1'h0);
  endtask
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(60));
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    @(posedge clk_sys_in);
    axr(FWSR_REG_STAT);
    chk("stat_reset", r[5:0], 32'h8);
    // k: 0 program, 1 program that times out, 2 sector erase, 3 erase suspended
    for (k = 0; k < 4; k++) begin
      d = 8'($urandom % 240);
      a = $urandom & 32'hFFFFF;
      len <= 4'($urandom_range(1, 6));
      stuck <= k == 1;
      mode <= 2'(k == 0 ? 0 : k - 1);
      q.push_back(d);
      axw(FWSR_REG_ADDR, a);
      axw(FWSR_REG_DATA, {24'h0, d});
      axw(FWSR_REG_CMD, 32'(FWSR_CMD_WRITE));
      idle();
      chk("prog_data", i_flash.pd, q.pop_front());
      chk("flash_addr", flash_addr_out, a);
      chk("ready_line", r[FWSR_ST_RDY], k == 3);
      for (j = 0; j < 2; j++) begin
        axw(FWSR_REG_CMD, 32'(FWSR_CMD_READ));
        idle();
        chk("window_flag", r[FWSR_ST_WIN], k == 2 && j == 1);
        axr(FWSR_REG_DATA);
        chk("poll_bit", r[15], (k < 2) ? !d[7] : k == 3);
      end
      axw(FWSR_REG_CMD, 32'(FWSR_CMD_POLL));
      idle();
      chk("fail_flag", r[FWSR_ST_FAIL], k == 1);
      chk("done_flag", r[FWSR_ST_DONE], k != 1);
      chk("ready_after", r[FWSR_ST_RDY], 32'h1);
      if (k == 3) begin
        chk("susp_flag", r[FWSR_ST_SUSP], 32'h1);
        axw(FWSR_REG_DATA, 32'(FWSR_RESET_CMD));
        axw(FWSR_REG_CMD, 32'(FWSR_CMD_WRITE));
        idle();
      end
      axw(FWSR_REG_CMD, 32'(FWSR_CMD_READ));
      idle();
      axr(FWSR_REG_DATA);
      chk("array_data", r[15:8], d);
    end
    complete_run();
  end
endmodule
